// ==== rtl/thrrel_top.sv ====
// Overview of operation
// - Each channel holds a signed primary limit, -999 to 9999, hysteresis centre.
// - Secondary limit, same range, used only in the two window modes.
// - Half dead band 0 to 999; output changes only outside limit +/- band.
// - Disabled function keeps relay off, except when the fault reaction forces it on.
// - Direct mode: on above primary+band, off below primary-band.
// - Inverted mode: off above primary+band, on below primary-band.
// - Inside window: on between low+band and high-band; limits ordered by compare.
// - Outside window: on above high+band or below low-band, off inside.
// - Bus mode: relay follows the serially written value, input ignored.
// - LED lit exactly when the channel is on, in every mode, whether its relay is fitted or not.
// - Bus relay state is not retained; reset returns it to default.
// - Engage only after the on condition held for the engage delay.
// - Release only after the off condition held for the release delay.
// - Condition ending early keeps state; timing restarts on next crossing.
// - Per-channel selector makes delays count in tenths of a second or in 6 s steps.
// - Fault reaction holds, forces on or forces off during a critical case.
// - Threshold and window modes: critical case is measurement over-range.
// - Bus mode: critical case is link silence longer than the limit.
// - Link silence limit 0 to 99 whole seconds, zero disables the check.
// - Forced-on reaction energises relay even with function disabled.
// - Comparator input selectable between live value and held peak value.
// - Unfitted relay channel still runs and drives its LED only.
// - Per-relay beep enable starts the buzzer when that relay activates.
// - Any front-panel button press silences an active buzzer.
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
module thrrel_top #(
    parameter int          NCH          = 4,
    parameter int unsigned TENTH_CYC    = thrrel_pkg::TENTH_CYCLES
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_RST_N,
    input  wire logic [7:0]              I_ADDR,
    input  wire logic [15:0]             I_WDATA,
    input  wire logic                    I_WR,
    input  wire logic                    I_RD,
    output logic      [15:0]             O_RDATA,
    input  wire logic                    I_SAMPLE_VALID,
    input  wire logic signed [15:0]      I_LIVE_VALUE,
    input  wire logic signed [15:0]      I_PEAK_VALUE,
    input  wire logic                    I_OVER_RANGE,
    input  wire logic                    I_FRAME_RX,
    input  wire logic [3:0]              I_BUTTONS,
    output logic      [NCH-1:0]          O_RELAY,
    output logic      [NCH-1:0]          O_LED,
    output logic                         O_BUZZER
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] btn_s1_q;
    logic [3:0] btn_s2_q;
    logic       btn_any_q;
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            btn_s1_q  <= 4'h0;
            btn_s2_q  <= 4'h0;
            btn_any_q <= 1'b0;
        end
        else
        begin
            btn_s1_q  <= I_BUTTONS;
            btn_s2_q  <= btn_s1_q;
            btn_any_q <= |btn_s2_q;
        end
    end

    // ------------------------------------------------------------
    // Time base: 0.1 s ticks, 1 s ticks
    // ------------------------------------------------------------
    logic [31:0] pre_q;
    logic        tenth_q;
    logic [3:0]  sec_div_q;
    logic        sec_q;
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            pre_q     <= 32'h0;
            tenth_q   <= 1'b0;
            sec_div_q <= 4'h0;
            sec_q     <= 1'b0;
        end
        else
        begin
            tenth_q <= 1'b0;
            sec_q   <= 1'b0;
            if (pre_q >= 32'(TENTH_CYC - 1))
            begin
                pre_q   <= 32'h0;
                tenth_q <= 1'b1;
                if (sec_div_q == 4'(thrrel_pkg::SEC_TENTHS - 1))
                begin
                    sec_div_q <= 4'h0;
                    sec_q     <= 1'b1;
                end
                else
                    sec_div_q <= sec_div_q + 4'h1;
            end
            else
                pre_q <= pre_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Link silence watchdog
    // ------------------------------------------------------------
    logic [6:0] link_limit_q;
    logic [6:0] silence_q;
    logic       link_lost_q;
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            silence_q   <= 7'h00;
            link_lost_q <= 1'b0;
        end
        else if (I_FRAME_RX || link_limit_q == 7'h00)
        begin
            silence_q   <= 7'h00;
            link_lost_q <= 1'b0;
        end
        else if (sec_q && !link_lost_q)
        begin
            silence_q <= silence_q + 7'h01;
            if (silence_q >= link_limit_q)
                link_lost_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Global registers
    // ------------------------------------------------------------
    logic [NCH-1:0] beep_en_q;
    logic [NCH-1:0] bus_relay_q;
    logic [NCH-1:0] fitted_q;
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            link_limit_q <= thrrel_pkg::RST_LINK_LIMIT;
            beep_en_q    <= '0;
            bus_relay_q  <= '0;
            fitted_q     <= '1;
        end
        else if (I_WR)
        begin
            if (I_ADDR == thrrel_pkg::REG_LINK_LIMIT)
                link_limit_q <= (I_WDATA > 16'(thrrel_pkg::LINK_LIMIT_MAX))
                    ? thrrel_pkg::LINK_LIMIT_MAX : I_WDATA[6:0];
            else if (I_ADDR == thrrel_pkg::REG_BEEP_EN)
                beep_en_q <= I_WDATA[NCH-1:0];
            else if (I_ADDR == thrrel_pkg::REG_BUS_RELAY)
                bus_relay_q <= I_WDATA[NCH-1:0];
            else if (I_ADDR == thrrel_pkg::REG_FITTED)
                fitted_q <= I_WDATA[NCH-1:0];
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [NCH-1:0] state_q;
    logic [15:0]    ch_rd [NCH];

    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        localparam logic [7:0] BASE = 8'(c) * thrrel_pkg::CH_STRIDE;
        logic signed [15:0] prim_q;
        logic signed [15:0] sec_q2;
        logic [15:0]        band_q;
        logic [7:0]         mode_q;
        logic [15:0]        on_dly_q;
        logic [15:0]        off_dly_q;
        logic [15:0]        tmr_q;
        logic [9:0]         sub_q;
        logic               pend_q;
        logic               sel;

        always_ff @(posedge I_CLK)
        begin
            if (!I_RST_N)
            begin
                prim_q    <= thrrel_pkg::RST_PRIMARY;
                sec_q2    <= thrrel_pkg::RST_SECONDARY;
                band_q    <= thrrel_pkg::RST_DEAD_BAND;
                mode_q    <= thrrel_pkg::RST_MODE;
                on_dly_q  <= thrrel_pkg::RST_DELAY;
                off_dly_q <= thrrel_pkg::RST_DELAY;
            end
            else if (I_WR)
            begin
                if (I_ADDR == BASE + thrrel_pkg::OFF_PRIMARY)
                    prim_q <= clamp(I_WDATA);
                else if (I_ADDR == BASE + thrrel_pkg::OFF_SECONDARY)
                    sec_q2 <= clamp(I_WDATA);
                else if (I_ADDR == BASE + thrrel_pkg::OFF_DEAD_BAND)
                    band_q <= (I_WDATA > thrrel_pkg::DEAD_BAND_MAX)
                        ? thrrel_pkg::DEAD_BAND_MAX : I_WDATA;
                else if (I_ADDR == BASE + thrrel_pkg::OFF_MODE)
                    mode_q <= I_WDATA[7:0];
                else if (I_ADDR == BASE + thrrel_pkg::OFF_ENGAGE_DLY)
                    on_dly_q <= (I_WDATA > thrrel_pkg::DELAY_MAX)
                        ? thrrel_pkg::DELAY_MAX : I_WDATA;
                else if (I_ADDR == BASE + thrrel_pkg::OFF_RELEASE_DLY)
                    off_dly_q <= (I_WDATA > thrrel_pkg::DELAY_MAX)
                        ? thrrel_pkg::DELAY_MAX : I_WDATA;
            end
        end

        // Comparison in 18 bits so limit +/- band never wraps
        logic signed [17:0] x, lo, hi, b;
        logic want_on, want_off, crit, tgt, force_v, forced;
        thrrel_pkg::thrrel_func_e  fn;
        thrrel_pkg::thrrel_react_e rc;
        always_comb
        begin
            fn  = thrrel_pkg::thrrel_func_e'(mode_q[2:0]);
            rc  = thrrel_pkg::thrrel_react_e'(mode_q[5:4]);
            sel = mode_q[thrrel_pkg::MODE_SRC_BIT];
            x   = 18'(sel ? I_PEAK_VALUE : I_LIVE_VALUE);
            b   = 18'(signed'({2'b00, band_q}));
            lo  = 18'(prim_q);
            hi  = 18'(prim_q);
            if (fn == thrrel_pkg::THRREL_INSIDE ||
                fn == thrrel_pkg::THRREL_OUTSIDE)
            begin
                lo = (prim_q < sec_q2) ? 18'(prim_q) : 18'(sec_q2);
                hi = (prim_q < sec_q2) ? 18'(sec_q2) : 18'(prim_q);
            end
            want_on  = 1'b0;
            want_off = 1'b0;
            crit     = I_OVER_RANGE;
            case (fn)
                thrrel_pkg::THRREL_DIRECT:
                begin
                    want_on  = x > lo + b;
                    want_off = x < lo - b;
                end
                thrrel_pkg::THRREL_INVERTED:
                begin
                    want_on  = x < lo - b;
                    want_off = x > lo + b;
                end
                thrrel_pkg::THRREL_INSIDE:
                begin
                    want_on  = (x > lo + b) && (x < hi - b);
                    want_off = (x < lo - b) || (x > hi + b);
                end
                thrrel_pkg::THRREL_OUTSIDE:
                begin
                    want_on  = (x > hi + b) || (x < lo - b);
                    want_off = (x > lo + b) && (x < hi - b);
                end
                thrrel_pkg::THRREL_BUS:
                begin
                    crit     = link_lost_q;
                    want_on  = bus_relay_q[c];
                    want_off = !bus_relay_q[c];
                end
                default:
                    want_off = 1'b1;
            endcase
            forced  = crit && rc != thrrel_pkg::THRREL_HOLD;
            force_v = (rc == thrrel_pkg::THRREL_FORCE_ON);
            tgt     = state_q[c] ? !want_off : want_on;
            if (crit && rc == thrrel_pkg::THRREL_HOLD)
                tgt = state_q[c];
        end

        // Delay timer in tenths, with 60-tenth (6 s) prescale
        logic [15:0] limit;
        logic        tick;
        assign limit = state_q[c] ? off_dly_q : on_dly_q;
        assign tick  = tenth_q && (!mode_q[thrrel_pkg::MODE_UNIT_BIT] ||
            sub_q == 10'(thrrel_pkg::MIN_TENTHS / thrrel_pkg::SEC_TENTHS
            - 1));

        always_ff @(posedge I_CLK)
        begin
            if (!I_RST_N)
            begin
                state_q[c] <= 1'b0;
                tmr_q      <= 16'h0;
                sub_q      <= 10'h0;
                pend_q     <= 1'b0;
            end
            else if (forced)
            begin
                state_q[c] <= force_v;
                pend_q     <= 1'b0;
                tmr_q      <= 16'h0;
                sub_q      <= 10'h0;
            end
            else if (tgt == state_q[c])
            begin
                pend_q <= 1'b0;
                tmr_q  <= 16'h0;
                sub_q  <= 10'h0;
            end
            else if (limit == 16'h0 || (pend_q && tmr_q >= limit))
            begin
                state_q[c] <= tgt;
                pend_q     <= 1'b0;
                tmr_q      <= 16'h0;
            end
            else
            begin
                pend_q <= 1'b1;
                if (tenth_q)
                    sub_q <= tick ? 10'h0 : sub_q + 10'h1;
                if (tick && pend_q)
                    tmr_q <= tmr_q + 16'h1;
            end
        end

        always_comb
        begin
            ch_rd[c] = 16'h0000;
            if (I_ADDR == BASE + thrrel_pkg::OFF_PRIMARY)
                ch_rd[c] = prim_q;
            else if (I_ADDR == BASE + thrrel_pkg::OFF_SECONDARY)
                ch_rd[c] = sec_q2;
            else if (I_ADDR == BASE + thrrel_pkg::OFF_DEAD_BAND)
                ch_rd[c] = band_q;
            else if (I_ADDR == BASE + thrrel_pkg::OFF_MODE)
                ch_rd[c] = {8'h00, mode_q};
            else if (I_ADDR == BASE + thrrel_pkg::OFF_ENGAGE_DLY)
                ch_rd[c] = on_dly_q;
            else if (I_ADDR == BASE + thrrel_pkg::OFF_RELEASE_DLY)
                ch_rd[c] = off_dly_q;
            else if (I_ADDR == BASE + thrrel_pkg::OFF_STATUS)
                ch_rd[c] = {13'h0, crit, pend_q, state_q[c]};
        end
    end

    function automatic logic signed [15:0] clamp(input logic [15:0] v);
        logic signed [15:0] s;
        s = signed'(v);
        if (s < thrrel_pkg::LIMIT_MIN)
            return thrrel_pkg::LIMIT_MIN;
        if (s > thrrel_pkg::LIMIT_MAX)
            return thrrel_pkg::LIMIT_MAX;
        return s;
    endfunction

    // ------------------------------------------------------------
    // Outputs, buzzer and read port
    // ------------------------------------------------------------
    logic [NCH-1:0] prev_q;
    logic [15:0]    rd_d;
    always_comb
    begin
        rd_d = 16'h0000;
        for (int i = 0; i < NCH; i++)
            rd_d = rd_d | ch_rd[i];
        if (I_ADDR == thrrel_pkg::REG_LINK_LIMIT)
            rd_d = {9'h0, link_limit_q};
        else if (I_ADDR == thrrel_pkg::REG_BEEP_EN)
            rd_d = 16'(beep_en_q);
        else if (I_ADDR == thrrel_pkg::REG_BUS_RELAY)
            rd_d = 16'(bus_relay_q);
        else if (I_ADDR == thrrel_pkg::REG_FITTED)
            rd_d = 16'(fitted_q);
        else if (I_ADDR == thrrel_pkg::REG_GLOBAL_STAT)
            rd_d = {14'h0, O_BUZZER, link_lost_q};
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            O_RDATA  <= 16'h0000;
            O_RELAY  <= '0;
            O_LED    <= '0;
            O_BUZZER <= 1'b0;
            prev_q   <= '0;
        end
        else
        begin
            O_RDATA <= I_RD ? rd_d : 16'h0000;
            O_RELAY <= state_q & fitted_q;
            O_LED   <= state_q;
            prev_q  <= state_q;
            if (|(state_q & ~prev_q & beep_en_q))
                O_BUZZER <= 1'b1;
            else if (btn_any_q)
                O_BUZZER <= 1'b0;
        end
    end

endmodule

// ==== inc/thrrel_pkg.sv ====
package thrrel_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    // Per-channel block: base = channel * CH_STRIDE
    localparam logic [7:0] CH_STRIDE       = 8'h08;
    localparam logic [7:0] OFF_PRIMARY     = 8'h00;
    localparam logic [7:0] OFF_SECONDARY   = 8'h01;
    localparam logic [7:0] OFF_DEAD_BAND   = 8'h02;
    localparam logic [7:0] OFF_MODE        = 8'h03;
    localparam logic [7:0] OFF_ENGAGE_DLY  = 8'h04;
    localparam logic [7:0] OFF_RELEASE_DLY = 8'h05;
    localparam logic [7:0] OFF_STATUS      = 8'h06;
    localparam logic [7:0] REG_LINK_LIMIT  = 8'h20;
    localparam logic [7:0] REG_BEEP_EN     = 8'h21;
    localparam logic [7:0] REG_BUS_RELAY   = 8'h22;
    localparam logic [7:0] REG_FITTED      = 8'h23;
    localparam logic [7:0] REG_GLOBAL_STAT = 8'h24;

    // Mode register fields
    localparam int MODE_FUNC_LSB   = 0;
    localparam int MODE_REACT_LSB  = 4;
    localparam int MODE_UNIT_BIT   = 6;
    localparam int MODE_SRC_BIT    = 7;

    // ------------------------------------------------------------
    // Ranges and reset values
    // ------------------------------------------------------------
    localparam logic signed [15:0] LIMIT_MIN  = -16'sd999;
    localparam logic signed [15:0] LIMIT_MAX  = 16'sd9999;
    localparam logic [15:0] DEAD_BAND_MAX     = 16'd999;
    localparam logic [15:0] DELAY_MAX         = 16'd999;
    localparam logic [6:0]  LINK_LIMIT_MAX    = 7'd99;
    localparam logic [15:0] RST_PRIMARY       = 16'h0000;
    localparam logic [15:0] RST_SECONDARY     = 16'h0000;
    localparam logic [15:0] RST_DEAD_BAND     = 16'h0000;
    localparam logic [7:0]  RST_MODE          = 8'h00;
    localparam logic [15:0] RST_DELAY         = 16'h0000;
    localparam logic [6:0]  RST_LINK_LIMIT    = 7'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int TENTH_SEC_MS    = 100;
    localparam int TENTH_CYCLES    = CLK_HZ / 1000 * TENTH_SEC_MS;
    localparam int SEC_TENTHS      = 10;
    localparam int MIN_TENTHS      = 600;

    typedef enum logic [2:0] {
        THRREL_DISABLED,
        THRREL_DIRECT,
        THRREL_INVERTED,
        THRREL_INSIDE,
        THRREL_OUTSIDE,
        THRREL_BUS
    } thrrel_func_e;

    typedef enum logic [1:0] {
        THRREL_HOLD,
        THRREL_FORCE_ON,
        THRREL_FORCE_OFF
    } thrrel_react_e;

endpackage

// ==== tb/thrrel_loads.sv ====
module thrrel_loads #(
    parameter int NCH = 4
) (
    input  wire logic           i_clk,
    input  wire logic           i_rst_n,
    input  wire logic [NCH-1:0] i_coil,
    input  wire logic [NCH-1:0] i_lamp,
    input  wire logic           i_horn,
    output logic      [7:0]     o_beeps,
    output logic      [7:0]     o_faults
);
    timeunit 1ns;
    timeprecision 1ps;
    logic horn_q;
    // --------------------------------------------------------
    // Coils, lamps and horn only listen; faults are logged
    // --------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            horn_q   <= 1'b0;
            o_beeps  <= 8'h00;
            o_faults <= 8'h00;
        end
        else
        begin
            horn_q <= i_horn;
            if (i_horn && !horn_q) o_beeps <= o_beeps + 8'h01;
            if (|(i_coil & ~i_lamp)) o_faults <= o_faults + 8'h01;
        end
    end
endmodule

// ==== tb/thrrel_properties.sv ====
module thrrel_properties #(
    parameter int          NCH       = 4,
    parameter int unsigned TENTH_CYC = 10
) (
    input wire logic               I_CLK,
    input wire logic               I_RST_N,
    input wire logic [7:0]         I_ADDR,
    input wire logic [15:0]        I_WDATA,
    input wire logic               I_WR,
    input wire logic               I_RD,
    input wire logic [15:0]        O_RDATA,
    input wire logic               I_SAMPLE_VALID,
    input wire logic signed [15:0] I_LIVE_VALUE,
    input wire logic signed [15:0] I_PEAK_VALUE,
    input wire logic               I_OVER_RANGE,
    input wire logic               I_FRAME_RX,
    input wire logic [3:0]         I_BUTTONS,
    input wire logic [NCH-1:0]     O_RELAY,
    input wire logic [NCH-1:0]     O_LED,
    input wire logic               O_BUZZER
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        [7:0]  mode_q;
    logic signed [15:0] prim_q;
    logic signed [15:0] band_q;
    // --------------------------------------------------------
    // Shadow of channel 0 setup, only in-range values expected
    // --------------------------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            mode_q <= 8'h00;
            prim_q <= 16'sh0000;
            band_q <= 16'sh0000;
        end
        else if (I_WR)
        begin
            if (I_ADDR == thrrel_pkg::OFF_MODE) mode_q <= I_WDATA[7:0];
            if (I_ADDR == thrrel_pkg::OFF_PRIMARY) prim_q <= I_WDATA;
            if (I_ADDR == thrrel_pkg::OFF_DEAD_BAND) band_q <= I_WDATA;
        end
    end
    wire logic   [2:0]  fn = mode_q[2:0];
    wire logic   [1:0]  rc = mode_q[5:4];
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    a_led_covers_relay: assert property ((O_RELAY & ~O_LED) == '0)
        else $error("relay closed with led dark");
    a_reset_all_quiet: assert property ($rose(I_RST_N) |->
        O_RELAY == '0 && O_LED == '0 && !O_BUZZER) else $error("busy at reset");
    a_disabled_stays_off: assert property (
        (fn == 3'h0 && rc != 2'h1 && !I_OVER_RANGE)[*3] |-> !O_LED[0])
        else $error("disabled channel lit");
    a_fault_forces_on: assert property (
        (rc == 2'h1 && fn != 3'h5 && I_OVER_RANGE)[*3] |-> O_LED[0])
        else $error("forced on missing");
    a_fault_forces_off: assert property (
        (rc == 2'h2 && fn != 3'h5 && I_OVER_RANGE)[*3] |-> !O_LED[0])
        else $error("forced off missing");
    a_fault_hold_freeze: assert property (
        (rc == 2'h0 && fn inside {[3'h1:3'h4]} && I_OVER_RANGE)[*3]
        |=> $stable(O_LED[0])) else $error("held state moved");
    a_direct_above_on: assert property ((fn == 3'h1 && !mode_q[7] &&
        !I_OVER_RANGE && I_LIVE_VALUE > prim_q + band_q)[*3] |-> O_LED[0])
        else $error("direct mode not engaged");
    a_direct_below_off: assert property ((fn == 3'h1 && !mode_q[7] &&
        !I_OVER_RANGE && I_LIVE_VALUE < prim_q - band_q)[*3] |-> !O_LED[0])
        else $error("direct mode not released");
    a_beep_has_cause: assert property ($rose(O_BUZZER) |-> ##[0:2] (|O_LED))
        else $error("buzzer without relay");
    a_button_mutes: assert property ((|I_BUTTONS)[*5] |-> !O_BUZZER)
        else $error("buzzer not silenced");
endmodule

bind thrrel_top thrrel_properties #(.NCH(NCH), .TENTH_CYC(TENTH_CYC))
    thrrel_properties_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_SAMPLE_VALID(I_SAMPLE_VALID), .I_LIVE_VALUE(I_LIVE_VALUE),
    .I_PEAK_VALUE(I_PEAK_VALUE), .I_OVER_RANGE(I_OVER_RANGE),
    .I_FRAME_RX(I_FRAME_RX), .I_BUTTONS(I_BUTTONS), .O_RELAY(O_RELAY),
    .O_LED(O_LED), .O_BUZZER(O_BUZZER));

// ==== tb/tb_thrrel_top.sv ====
module tb_thrrel_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               I_CLK, I_RST_N, I_WR, I_RD, I_SAMPLE_VALID;
    logic               I_OVER_RANGE, I_FRAME_RX, O_BUZZER;
    logic        [7:0]  I_ADDR, beeps, faults;
    logic        [15:0] I_WDATA, O_RDATA;
    logic signed [15:0] I_LIVE_VALUE, I_PEAK_VALUE;
    logic        [3:0]  I_BUTTONS, O_RELAY, O_LED;
    int                 fail_count = 0, checks = 0;
    logic        [7:0]  ta [5] = '{8'h18, 8'h19, 8'h1A, 8'h1C, 8'h20};
    logic        [15:0] tw [5] = '{16'h2710, 16'hFC18, 16'h03E8, 16'h03E8, 16'h0064};
    logic        [15:0] te [5] = '{16'h270F, 16'hFC19, 16'h03E7, 16'h03E7, 16'h0063};

    thrrel_top #(.NCH(4), .TENTH_CYC(10)) thrrel_top_i (.I_CLK(I_CLK),
        .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
        .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SAMPLE_VALID(I_SAMPLE_VALID),
        .I_LIVE_VALUE(I_LIVE_VALUE), .I_PEAK_VALUE(I_PEAK_VALUE),
        .I_OVER_RANGE(I_OVER_RANGE), .I_FRAME_RX(I_FRAME_RX),
        .I_BUTTONS(I_BUTTONS), .O_RELAY(O_RELAY), .O_LED(O_LED),
        .O_BUZZER(O_BUZZER));
    thrrel_loads #(.NCH(4)) thrrel_loads_i (.i_clk(I_CLK), .i_rst_n(I_RST_N),
        .i_coil(O_RELAY), .i_lamp(O_LED), .i_horn(O_BUZZER), .o_beeps(beeps),
        .o_faults(faults));
    // --------------------------------------------------------
    // Access tasks
    // --------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge I_CLK);
        I_WR <= 1'b1;
        I_ADDR <= a;
        I_WDATA <= d;
        @(posedge I_CLK);
        I_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge I_CLK);
        I_RD <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLK);
        I_RD <= 1'b0;
        #1 chk("rdata", e, O_RDATA);
    endtask
    // Sets input and fault level, waits n cycles, then looks at one led
    task automatic led(input logic [15:0] v, input logic o, input int ch,
                       input int n, input logic e);
        @(posedge I_CLK);
        I_LIVE_VALUE <= v;
        I_OVER_RANGE <= o;
        repeat (n) @(posedge I_CLK);
        #1 chk("led", {15'h0000, e}, {15'h0000, O_LED[ch]});
    endtask
    task automatic frame();
        @(posedge I_CLK);
        I_FRAME_RX <= 1'b1;
        @(posedge I_CLK);
        I_FRAME_RX <= 1'b0;
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // --------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------
    initial
    begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end
    initial
    begin
        repeat (12000) @(posedge I_CLK);
        fail_count++;
        end_of_test();
    end
    initial
    begin
        {I_RST_N, I_WR, I_RD, I_OVER_RANGE, I_FRAME_RX} = 5'h00;
        I_SAMPLE_VALID = 1'b1;
        {I_ADDR, I_WDATA, I_LIVE_VALUE, I_PEAK_VALUE, I_BUTTONS} = '0;
        repeat (3) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        rd(8'h03, 16'h0000);
        rd(8'h22, 16'h0000);
        rd(8'h23, 16'h000F);
        rd(8'h30, 16'h0000);
        for (int i = 0; i < 5; i++)
        begin
            wr(ta[i], tw[i]);
            rd(ta[i], te[i]);
        end
        wr(8'h20, 16'h0000);
        wr(8'h00, 16'h0064);
        wr(8'h02, 16'h000A);
        wr(8'h03, 16'h0001);
        led(16'h006F, 0, 0, 6, 1);
        led(16'h005F, 0, 0, 6, 1);
        led(16'h0059, 0, 0, 6, 0);
        wr(8'h03, 16'h0002);
        led(16'h0059, 0, 0, 6, 1);
        led(16'h006F, 0, 0, 6, 0);
        wr(8'h00, 16'h00C8);
        wr(8'h01, 16'h0064);
        wr(8'h03, 16'h0003);
        led(16'h0096, 0, 0, 6, 1);
        led(16'h00FA, 0, 0, 6, 0);
        wr(8'h03, 16'h0004);
        led(16'h0096, 0, 0, 6, 0);
        led(16'h00FA, 0, 0, 6, 1);
        led(16'h0032, 0, 0, 6, 1);
        wr(8'h00, 16'h0064);
        wr(8'h03, 16'h0005);
        wr(8'h22, 16'h0001);
        led(16'h0032, 0, 0, 6, 1);
        wr(8'h22, 16'h0000);
        led(16'h0096, 0, 0, 6, 0);
        wr(8'h03, 16'h0025);
        wr(8'h20, 16'h0001);
        frame();
        wr(8'h22, 16'h0001);
        led(16'h0096, 0, 0, 40, 1);
        led(16'h0096, 0, 0, 400, 0);
        rd(8'h24, 16'h0001);
        frame();
        led(16'h0096, 0, 0, 6, 1);
        wr(8'h20, 16'h0000);
        wr(8'h03, 16'h0010);
        led(16'h0096, 1, 0, 6, 1);
        led(16'h0096, 0, 0, 6, 0);
        wr(8'h03, 16'h0021);
        led(16'h006F, 1, 0, 6, 0);
        led(16'h006F, 0, 0, 6, 1);
        wr(8'h03, 16'h0001);
        led(16'h0059, 1, 0, 6, 1);
        led(16'h0059, 0, 0, 6, 0);
        wr(8'h21, 16'h0001);
        led(16'h006F, 0, 0, 6, 1);
        chk("buzzer", 16'h0001, {15'h0000, O_BUZZER});
        @(posedge I_CLK);
        I_BUTTONS <= 4'h4;
        repeat (6) @(posedge I_CLK);
        #1 chk("buzzer", 16'h0000, {15'h0000, O_BUZZER});
        @(posedge I_CLK);
        I_BUTTONS <= 4'h0;
        chk("beeps", 16'h0001, {8'h00, beeps});
        wr(8'h08, 16'h0064);
        wr(8'h0A, 16'h000A);
        wr(8'h0C, 16'h0002);
        wr(8'h0D, 16'h0002);
        led(16'h0059, 0, 1, 6, 0);
        wr(8'h0B, 16'h0001);
        led(16'h006F, 0, 1, 6, 0);
        led(16'h006F, 0, 1, 40, 1);
        led(16'h0059, 0, 1, 6, 1);
        led(16'h006F, 0, 1, 40, 1);
        led(16'h0059, 0, 1, 50, 0);
        wr(8'h0B, 16'h0041);
        wr(8'h0C, 16'h0001);
        led(16'h006F, 0, 1, 300, 0);
        led(16'h006F, 0, 1, 1700, 1);
        wr(8'h10, 16'h0064);
        wr(8'h12, 16'h000A);
        wr(8'h13, 16'h0081);
        @(posedge I_CLK);
        I_PEAK_VALUE <= 16'sh0096;
        led(16'h0000, 0, 2, 6, 1);
        chk("relay", 16'h0001, {15'h0000, O_RELAY[2]});
        wr(8'h23, 16'h000B);
        led(16'h0000, 0, 2, 6, 1);
        chk("relay", 16'h0000, {15'h0000, O_RELAY[2]});
        chk("faults", 16'h0000, {8'h00, faults});
        @(posedge I_CLK);
        I_RST_N <= 1'b0;
        repeat (3) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        rd(8'h22, 16'h0000);
        end_of_test();
    end
endmodule
